// ==== shared/ctp_consts.vh ====
// Constants for the cascaded 16-bit timer, PWM and pulse generator.
`ifndef CTP_CONSTS_VH
`define CTP_CONSTS_VH

// Register byte offsets.
`define CTP_ADR_LOWER_CTRL   8'h00
`define CTP_ADR_UPPER_CTRL   8'h04
`define CTP_ADR_CMP_LO       8'h08
`define CTP_ADR_CMP_HI       8'h0c
`define CTP_ADR_DUTY_LO      8'h10
`define CTP_ADR_DUTY_HI      8'h14
`define CTP_ADR_STATUS       8'h18

// Lower half control fields.
`define CTP_LC_SEL_LSB       0
`define CTP_LC_SEL_MSB       1
`define CTP_LC_EXT_BIT       2
`define CTP_LC_DIV_BIT       3

// Upper half control fields.
`define CTP_UC_MODE_LSB      0
`define CTP_UC_MODE_MSB      1
`define CTP_UC_RUN_BIT       3
`define CTP_UC_FFINIT_BIT    7

// Mode codes.
`define CTP_MODE_TIMER       2'h0
`define CTP_MODE_EVENT       2'h1
`define CTP_MODE_PWM         2'h2
`define CTP_MODE_PPG         2'h3

// Prescaler division exponents for select codes 0 to 3.
`define CTP_DIV_EXP0         4'hb
`define CTP_DIV_EXP1         4'h7
`define CTP_DIV_EXP2         4'h5
`define CTP_DIV_EXP3         4'h3
`define CTP_PRESC_W          13

// Reset values and the counter maximum.
`define CTP_RST_CTRL         8'h00
`define CTP_RST_WORD         16'h0000
`define CTP_CNT_MAX          16'hffff

`endif

// ==== core/ctp_prescaler.v ====
// Prescaler that issues one tick per selected power-of-two division of the system clock.
`timescale 1ns/1ps
`include "ctp_consts.vh"

module ctp_prescaler (
	// Clock and reset.
	input  wire       clk_i,
	input  wire       rst_i,
	// Selection.
	input  wire [1:0] sel_i,
	input  wire       dbl_i,
	// Tick out.
	output wire       tick_o
);

	reg  [`CTP_PRESC_W-1:0] div_q;
	reg  [3:0]              exp_w;
	wire [3:0]              exp_full;
	wire [`CTP_PRESC_W-1:0] mask_w;

	always @* begin
		case (sel_i)
			2'h0: exp_w = `CTP_DIV_EXP0;
			2'h1: exp_w = `CTP_DIV_EXP1;
			2'h2: exp_w = `CTP_DIV_EXP2;
			default: exp_w = `CTP_DIV_EXP3;
		endcase
	end

	// The doubling option adds one to the exponent.
	assign exp_full = exp_w + {3'h0, dbl_i};
	assign mask_w   = ~({`CTP_PRESC_W{1'b1}} << exp_full);
	assign tick_o   = ((div_q & mask_w) == mask_w);

	always @(posedge clk_i) begin
		if (rst_i) begin
			div_q <= {`CTP_PRESC_W{1'b0}};
		end else begin
			div_q <= div_q + {{(`CTP_PRESC_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

// ==== core/ctp_timer.v ====
// Cascaded 16-bit timer, event counter, PWM and pulse generator with a Wishbone slave.
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "ctp_consts.vh"

module ctp_timer (
	// Clock and reset.
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave.
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// External event input.
	input  wire        event_input_pin_i,
	// Outputs.
	output wire        pwm_output_pin_o,
	output wire        pulse_gen_output_pin_o,
	output reg         timer_interrupt_o
);

	reg  [7:0]  lower_half_control_q;
	reg  [7:0]  upper_half_control_q;
	reg  [15:0] compare_q;
	reg  [7:0]  compare_low_stage_q;
	reg  [15:0] duty_active_q;
	reg  [15:0] duty_buffer_q;
	reg  [7:0]  duty_low_stage_q;
	reg         duty_pending_q;
	reg  [15:0] count_q;
	reg         output_flipflop_q;
	reg         event_prev_q;
	reg  [15:0] count_d;
	reg         ff_d;
	reg         irq_d;
	reg         load_duty_d;

	wire        req_w;
	wire        wr_w;
	wire [1:0]  mode_w;
	wire        run_w;
	wire        ext_w;
	wire        presc_tick_w;
	wire        event_fall_w;
	wire        tick_w;
	wire [15:0] count_inc_w;
	wire        wr_upper_w;

	// A request is taken at the edge where ack rises.
	assign req_w      = cyc_i & stb_i & ~ack_o;
	assign wr_w       = req_w & we_i & sel_i[0];
	assign wr_upper_w = wr_w & (adr_i == `CTP_ADR_UPPER_CTRL);
	assign mode_w     = upper_half_control_q[`CTP_UC_MODE_MSB:`CTP_UC_MODE_LSB];
	assign run_w      = upper_half_control_q[`CTP_UC_RUN_BIT];
	assign ext_w      = lower_half_control_q[`CTP_LC_EXT_BIT];

	ctp_prescaler u_presc (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.sel_i  (lower_half_control_q[`CTP_LC_SEL_MSB:`CTP_LC_SEL_LSB]),
		.dbl_i  (lower_half_control_q[`CTP_LC_DIV_BIT]),
		.tick_o (presc_tick_w)
	);

	// Falling edge of the event pin, taken as synchronous.
	assign event_fall_w = event_prev_q & ~event_input_pin_i;
	// Event mode always counts the pin; other modes may pick it.
	assign tick_w = ((mode_w == `CTP_MODE_EVENT) || ext_w) ? event_fall_w : presc_tick_w;
	assign count_inc_w = count_q + 16'h0001;

	assign pwm_output_pin_o       = ~output_flipflop_q;
	assign pulse_gen_output_pin_o = ~output_flipflop_q;

	// Counter step.
	always @* begin
		count_d     = count_q;
		ff_d        = output_flipflop_q;
		irq_d       = 1'b0;
		load_duty_d = 1'b0;
		if (!run_w) begin
			count_d = `CTP_RST_WORD;
		end else if (tick_w) begin
			case (mode_w)
				`CTP_MODE_TIMER,
				`CTP_MODE_EVENT: begin
					if (count_inc_w == compare_q) begin
						count_d = `CTP_RST_WORD;
						irq_d   = 1'b1;
					end else begin
						count_d = count_inc_w;
					end
				end
				`CTP_MODE_PWM: begin
					if (count_q == `CTP_CNT_MAX) begin
						count_d     = `CTP_RST_WORD;
						ff_d        = ~output_flipflop_q;
						irq_d       = 1'b1;
						load_duty_d = 1'b1;
					end else begin
						count_d = count_inc_w;
						if (count_inc_w == duty_active_q) begin
							ff_d = ~output_flipflop_q;
						end
					end
				end
				default: begin
					if (count_inc_w == compare_q) begin
						count_d = `CTP_RST_WORD;
						ff_d    = ~output_flipflop_q;
						irq_d   = 1'b1;
					end else begin
						count_d = count_inc_w;
						if (count_inc_w == duty_active_q) begin
							ff_d = ~output_flipflop_q;
						end
					end
				end
			endcase
		end
	end

	// Counter, flip-flop and interrupt.
	always @(posedge clk_i) begin
		if (rst_i) begin
			count_q           <= `CTP_RST_WORD;
			output_flipflop_q <= 1'b0;
			timer_interrupt_o <= 1'b0;
			event_prev_q      <= 1'b1;
		end else begin
			count_q           <= count_d;
			timer_interrupt_o <= irq_d;
			event_prev_q      <= event_input_pin_i;
			// A control write while stopped loads the initial level; stopping holds it.
			if (wr_upper_w && !run_w) begin
				output_flipflop_q <= dat_i[`CTP_UC_FFINIT_BIT];
			end else begin
				output_flipflop_q <= ff_d;
			end
		end
	end

	// Register writes and duty transfer.
	always @(posedge clk_i) begin
		if (rst_i) begin
			lower_half_control_q <= `CTP_RST_CTRL;
			upper_half_control_q <= `CTP_RST_CTRL;
			compare_q            <= `CTP_RST_WORD;
			compare_low_stage_q  <= 8'h00;
			duty_active_q        <= `CTP_RST_WORD;
			duty_buffer_q        <= `CTP_RST_WORD;
			duty_low_stage_q     <= 8'h00;
			duty_pending_q       <= 1'b0;
		end else begin
			if (load_duty_d) begin
				duty_active_q  <= duty_buffer_q;
				duty_pending_q <= 1'b0;
			end else if (duty_pending_q && !run_w) begin
				duty_active_q  <= duty_buffer_q;
				duty_pending_q <= 1'b0;
			end
			if (wr_w) begin
				if (adr_i == `CTP_ADR_LOWER_CTRL) begin
					lower_half_control_q <= dat_i[7:0];
				end else if (adr_i == `CTP_ADR_UPPER_CTRL) begin
					upper_half_control_q <= dat_i[7:0];
				end else if (adr_i == `CTP_ADR_CMP_LO) begin
					compare_low_stage_q <= dat_i[7:0];
				end else if (adr_i == `CTP_ADR_CMP_HI) begin
					compare_q <= {dat_i[7:0], compare_low_stage_q};
				end else if (adr_i == `CTP_ADR_DUTY_LO) begin
					duty_low_stage_q <= dat_i[7:0];
				end else if (adr_i == `CTP_ADR_DUTY_HI) begin
					duty_buffer_q <= {dat_i[7:0], duty_low_stage_q};
					if (mode_w == `CTP_MODE_PWM) begin
						duty_pending_q <= 1'b1;
					end else begin
						duty_active_q  <= {dat_i[7:0], duty_low_stage_q};
						duty_pending_q <= 1'b0;
					end
				end
			end
		end
	end

	// Read data and acknowledge.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req_w;
			if (req_w && !we_i) begin
				if (adr_i == `CTP_ADR_LOWER_CTRL) begin
					dat_o <= {24'h00_0000, lower_half_control_q};
				end else if (adr_i == `CTP_ADR_UPPER_CTRL) begin
					dat_o <= {24'h00_0000, upper_half_control_q};
				end else if (adr_i == `CTP_ADR_CMP_LO) begin
					dat_o <= {24'h00_0000, compare_q[7:0]};
				end else if (adr_i == `CTP_ADR_CMP_HI) begin
					dat_o <= {24'h00_0000, compare_q[15:8]};
				end else if (adr_i == `CTP_ADR_DUTY_LO) begin
					dat_o <= {24'h00_0000, duty_buffer_q[7:0]};
				end else if (adr_i == `CTP_ADR_DUTY_HI) begin
					dat_o <= {24'h00_0000, duty_buffer_q[15:8]};
				end else if (adr_i == `CTP_ADR_STATUS) begin
					dat_o <= {15'h0000, output_flipflop_q, count_q};
				end else begin
					dat_o <= 32'h0000_0000;
				end
			end
		end
	end

endmodule

// ==== test/ctp_event_src.sv ====
// Event pulse source that drives the timer's external event pin.
`timescale 1ns/1ps
module ctp_event_src (
	// Clock.
	input	wire logic	clk_i,
	// Event pin.
	output	logic		event_o
);
	initial event_o = 1'b1;
	// Each pulse holds low and high for at least two cycles.
	task send(input int n);
		repeat (n) begin
			@(posedge clk_i);
			event_o <= 1'b0;
			repeat (2) @(posedge clk_i);
			event_o <= 1'b1;
			repeat (2) @(posedge clk_i);
		end
	endtask
endmodule

// ==== test/ctp_timer_properties.sv ====
// Port checks for the cascaded timer.
`timescale 1ns/1ps
module ctp_timer_props (
	// Clock and reset.
	input	wire		clk_i,
	input	wire		rst_i,
	// Bus.
	input	wire		cyc_i,
	input	wire		stb_i,
	input	wire		we_i,
	input	wire [7:0]	adr_i,
	input	wire [3:0]	sel_i,
	input	wire [31:0]	dat_i,
	input	wire [31:0]	dat_o,
	input	wire		ack_o,
	// Pins.
	input	wire		event_input_pin_i,
	input	wire		pwm_output_pin_o,
	input	wire		pulse_gen_output_pin_o,
	input	wire		timer_interrupt_o
);
	logic	run_q;
	wire	up_wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == 8'h04;
	always @(posedge clk_i) begin
		run_q <= rst_i ? 1'b0 : (up_wr ? dat_i[3] : run_q);
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_pins_agree: assert property (pwm_output_pin_o == pulse_gen_output_pin_o)
		else $error("pins differ");
	a_reset_clears: assert property (disable iff (1'b0) rst_i |=> pwm_output_pin_o
		&& !timer_interrupt_o && !ack_o) else $error("reset state wrong");
	a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack late");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	a_irq_single: assert property ($rose(timer_interrupt_o) |=> !timer_interrupt_o)
		else $error("interrupt too long");
	a_irq_needs_run: assert property (timer_interrupt_o |-> $past(run_q) || $past(run_q, 2))
		else $error("interrupt while stopped");
	a_stop_holds: assert property (!run_q && !$past(run_q) && !up_wr |=> $stable(pwm_output_pin_o))
		else $error("pin moved while stopped");
	a_init_loads: assert property (up_wr && !run_q |=> pwm_output_pin_o == !$past(dat_i[7]))
		else $error("initial level wrong");
	c_irq: cover property (timer_interrupt_o);
	c_init: cover property (up_wr && !run_q);
	c_read: cover property (ack_o && !we_i);
endmodule
bind ctp_timer ctp_timer_props ctp_timer_props_inst (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .event_input_pin_i(event_input_pin_i),
	.pwm_output_pin_o(pwm_output_pin_o), .pulse_gen_output_pin_o(pulse_gen_output_pin_o),
	.timer_interrupt_o(timer_interrupt_o));

// ==== test/testbench.sv ====
// Self-checking bench for the cascaded timer.
`timescale 1ns/1ps
module testbench;
	logic		clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0]	adr_i = 8'h00;
	logic [3:0]	sel_i = 4'h0;
	logic [31:0]	dat_i = 32'h0, rd;
	wire [31:0]	dat_o;
	wire		ack_o, ev, pwm, ppg, irq;
	int		num_errors = 0, comparisons = 0, cyc_n = 0, n_irq = 0, t0, t1, t2;
	int		ex[4] = '{11, 7, 5, 3};
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
	ctp_timer ctp_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.event_input_pin_i(ev), .pwm_output_pin_o(pwm), .pulse_gen_output_pin_o(ppg),
		.timer_interrupt_o(irq));
	ctp_event_src ctp_event_src_inst (.clk_i(clk_i), .event_o(ev));
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_n++;
		if (irq === 1'b1) n_irq++;
		if (cyc_n == 40000) begin
			num_errors++;
			final_report();
		end
	end
	task final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h0, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task w16(input logic [7:0] a, input logic [15:0] v);
		wb(a, 1'b1, v[7:0]);
		wb(a + 8'h04, 1'b1, v[15:8]);
	endtask
	task wirq(output int t);
		@(posedge clk_i);
		while (irq !== 1'b1) @(posedge clk_i);
		t = $time / 20;
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 8; a++) begin
			wb(8'(a * 4), 1'b0, 8'h00);
			`CHK(rd, 32'h0)
		end
		wb(8'h1c, 1'b1, 8'hff);
		wb(8'h1c, 1'b0, 8'h00);
		`CHK(rd, 32'h0)
		`CHK(pwm, 1'b1)
		$display("reset test done");
		w16(8'h08, 16'h0001);
		for (int s = 0; s < 8; s++) begin
			wb(8'h00, 1'b1, 8'((s & 3) | ((s & 4) << 1)));
			wb(8'h04, 1'b1, 8'h08);
			wirq(t0);
			wirq(t1);
			`CHK(t1 - t0, 1 << (ex[s % 4] + s / 4))
			wb(8'h04, 1'b1, 8'h00);
		end
		$display("timer test done");
		w16(8'h08, 16'h0003);
		wb(8'h04, 1'b1, 8'h09);
		t0 = n_irq;
		ctp_event_src_inst.send(2);
		repeat (4) @(posedge clk_i);
		`CHK(n_irq - t0, 0)
		ctp_event_src_inst.send(1);
		repeat (4) @(posedge clk_i);
		`CHK(n_irq - t0, 1)
		wb(8'h04, 1'b1, 8'h01);
		ctp_event_src_inst.send(3);
		repeat (4) @(posedge clk_i);
		`CHK(n_irq - t0, 1)
		$display("event test done");
		wb(8'h00, 1'b1, 8'h03);
		w16(8'h10, 16'h0002);
		wb(8'h04, 1'b1, 8'h0a);
		repeat (20) @(posedge clk_i);
		`CHK(pwm, 1'b0)
		w16(8'h10, 16'h0005);
		wb(8'h10, 1'b0, 8'h00);
		`CHK(rd, 32'h5)
		repeat (40) @(posedge clk_i);
		`CHK(pwm, 1'b0)
		wb(8'h04, 1'b1, 8'h02);
		repeat (40) @(posedge clk_i);
		`CHK(pwm, 1'b0)
		wb(8'h04, 1'b1, 8'h02);
		`CHK(pwm, 1'b1)
		wb(8'h04, 1'b1, 8'h82);
		`CHK(ppg, 1'b0)
		wb(8'h04, 1'b1, 8'h02);
		$display("pwm test done");
		w16(8'h08, 16'h0004);
		w16(8'h10, 16'h0002);
		wb(8'h04, 1'b1, 8'h0b);
		wirq(t0);
		while (ppg !== 1'b0) @(posedge clk_i);
		t1 = $time / 20;
		wirq(t2);
		`CHK(t1 - t0, 16)
		`CHK(t2 - t0, 32)
		`CHK(ppg, 1'b1)
		$display("pulse test done");
		final_report();
	end
endmodule
